/* core/timer_pair.sv */
// Purpose: Two 16-bit timers with prescalers, capture, PROGRAMMABLE_PULSE_GEN and cascade.
// Assumes: Single clock pclk at 200 MHz; pins synchronised by three flops.
// Notes: PROGRAMMABLE_PULSE_GEN period set by period register, duty by duty register.
`timescale 1ns/1ps

// Function
// - Run bit set clears timer A counter and starts it; cleared disables it.
// - Mode field picks timer/toggle, capture, PROGRAMMABLE_PULSE_GEN one-shot or PROGRAMMABLE_PULSE_GEN repeat.
// - Capture mode still raises the period-match interrupt.
// - Count-clear bit resets counter and reads back zero; writing zero does nothing.
// - Interrupt flag set by event; cleared by writing zero or acknowledge.
// - Timer B clock is fx/1,2,4,8,32,128,512 or timer A match.
// - With timer A match selected, timer B counts once per match.
// - Timer B compares counter with period register; match raises interrupt.
// - Timer B match resets its counter to zero.
// - Timer B counter clearable by its self-clearing count-clear bit.
// - Timer B toggles its toggle output on each match in timer mode.
// - Timer B capture mode loads counter into duty register on capture event.
// - Timer B drives PWM output in either PROGRAMMABLE_PULSE_GEN mode.
// - Timer A clock codes 0-6 give fx/2048..1; code 7 external clock.
// - Timer A matches when counter equals period register; match resets counter.
// - In PROGRAMMABLE_PULSE_GEN modes period register sets period, duty register sets duty.
// - PROGRAMMABLE_PULSE_GEN one-shot clears the run bit after exactly one pulse.
module timer_pair (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt acknowledges and requests
	input wire logic timer_a_irq_ack,
	input wire logic timer_b_irq_ack,
	output logic timer_a_irq,
	output logic timer_b_irq,
	// Pins
	input wire logic timer_a_ext_clk_in,
	input wire logic timer_a_capture_in,
	input wire logic timer_b_capture_in,
	output logic timer_a_toggle_out,
	output logic timer_a_pwm_out,
	output logic timer_b_toggle_out,
	output logic timer_b_pwm_out
);
	// Per-timer state, index 0 = timer A, 1 = timer B
	logic [7:0] ctrl_hi_ff [2];
	logic [7:0] ctrl_lo_ff [2];
	logic [15:0] period_ff [2];
	logic [15:0] duty_ff [2];
	logic [15:0] count_ff [2];
	logic [1:0] wave_ff;
	logic [1:0] tog_ff;
	logic [1:0] tick;
	logic [1:0] match;
	logic [1:0] cap_evt;
	// Prescaler width comes from the package; the slowest tap reads bit 10
	localparam int presc_width_l = timer_pair_pkg::presc_width;
	logic [presc_width_l-1:0] presc_ff;
	logic [2:0] ext_sync_ff;
	logic [2:0] capa_sync_ff;
	logic [2:0] capb_sync_ff;
	logic ext_prev_ff;
	logic capa_prev_ff;
	logic capb_prev_ff;
	logic ext_lvl;
	logic capa_lvl;
	logic capb_lvl;
	logic ext_edge;

	// APB decode
	logic wr_en;
	logic [9:0] word_idx;
	// Write only at the completing edge, so one access writes once
	assign wr_en = psel & penable & pwrite & pready;
	assign word_idx = paddr[11:2];

	// Prescaler shared by both timers, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_ff <= '0;
		end else begin
			presc_ff <= presc_ff + 1'b1;
		end
	end

	// Three-flop pin synchronisers; change taken when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_ff <= 3'h0;
			capa_sync_ff <= 3'h0;
			capb_sync_ff <= 3'h0;
			ext_prev_ff <= 1'b0;
			capa_prev_ff <= 1'b0;
			capb_prev_ff <= 1'b0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[1:0], timer_a_ext_clk_in};
			capa_sync_ff <= {capa_sync_ff[1:0], timer_a_capture_in};
			capb_sync_ff <= {capb_sync_ff[1:0], timer_b_capture_in};
			ext_prev_ff <= ext_lvl;
			capa_prev_ff <= capa_lvl;
			capb_prev_ff <= capb_lvl;
		end
	end
	assign ext_lvl = (ext_sync_ff[1] == ext_sync_ff[2]) ? ext_sync_ff[2] : ext_prev_ff;
	assign capa_lvl = (capa_sync_ff[1] == capa_sync_ff[2]) ? capa_sync_ff[2] : capa_prev_ff;
	assign capb_lvl = (capb_sync_ff[1] == capb_sync_ff[2]) ? capb_sync_ff[2] : capb_prev_ff;
	// Capture on rising edge only; the capture edge is fixed
	assign cap_evt[0] = capa_lvl & ~capa_prev_ff;
	assign cap_evt[1] = capb_lvl & ~capb_prev_ff;
	assign ext_edge = ctrl_lo_ff[0][timer_pair_pkg::bit_ext_edge] ? (ext_lvl & ~ext_prev_ff)
		: (~ext_lvl & ext_prev_ff);

	// Slowest tap divides by 2048, so a narrower prescaler cannot serve it
	if (presc_width_l < 11) begin : g_presc_check
		$error("prescaler narrower than the slowest tap");
	end

	// Prescaler tap: strobe once every 2**n cycles
	function automatic logic presc_tap(input logic [presc_width_l-1:0] p, input int n);
		logic [presc_width_l-1:0] mask;
		mask = presc_width_l'((1 << n) - 1);
		return (p & mask) == mask;
	endfunction

	// Count ticks
	always_comb begin
		case (ctrl_lo_ff[0][timer_pair_pkg::bit_clk_hi:timer_pair_pkg::bit_clk_lo])
			3'h0: tick[0] = presc_tap(presc_ff, 11);
			3'h1: tick[0] = presc_tap(presc_ff, 9);
			3'h2: tick[0] = presc_tap(presc_ff, 6);
			3'h3: tick[0] = presc_tap(presc_ff, 3);
			3'h4: tick[0] = presc_tap(presc_ff, 2);
			3'h5: tick[0] = presc_tap(presc_ff, 1);
			3'h6: tick[0] = 1'b1;
			default: tick[0] = ext_edge;
		endcase
	end

	// Timer B tick in its own process: its cascade input depends on tick[0]
	always_comb begin
		case (ctrl_lo_ff[1][timer_pair_pkg::bit_clk_hi:timer_pair_pkg::bit_clk_lo])
			3'h0: tick[1] = presc_tap(presc_ff, 9);
			3'h1: tick[1] = presc_tap(presc_ff, 7);
			3'h2: tick[1] = presc_tap(presc_ff, 5);
			3'h3: tick[1] = presc_tap(presc_ff, 3);
			3'h4: tick[1] = presc_tap(presc_ff, 2);
			3'h5: tick[1] = presc_tap(presc_ff, 1);
			3'h6: tick[1] = 1'b1;
			default: tick[1] = match[0];
		endcase
	end

	genvar t;
	generate
		for (t = 0; t < 2; t++) begin : g_timer
			localparam logic [7:0] base = (t == 0) ? timer_pair_pkg::idx_a_ctrl_low
				: timer_pair_pkg::idx_b_ctrl_low;
			logic run;
			logic [1:0] mode;
			logic programmable_pulse_gen;
			logic pol;
			logic wr_lo;
			logic wr_hi;
			logic start;
			logic sw_clear;
			logic one_done;
			assign run = ctrl_hi_ff[t][timer_pair_pkg::bit_run];
			assign mode = ctrl_hi_ff[t][timer_pair_pkg::bit_mode_hi:timer_pair_pkg::bit_mode_lo];
			assign programmable_pulse_gen = mode[1];
			assign pol = ctrl_lo_ff[t][timer_pair_pkg::bit_polarity];
			assign wr_lo = wr_en && (word_idx == {2'h0, base});
			assign wr_hi = wr_en && (word_idx == {2'h0, 8'(base + 8'h01)});
			assign start = wr_hi && pwdata[timer_pair_pkg::bit_run] && !run;
			assign sw_clear = wr_hi && pwdata[timer_pair_pkg::bit_count_clear];
			// Match only on a counting tick, so a parked counter fires once
			assign match[t] = run && tick[t] && (count_ff[t] == period_ff[t]);
			assign one_done = match[t] && (mode == timer_pair_pkg::mode_ppg_one);

			// Counter
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					count_ff[t] <= '0;
				end else if (start || sw_clear) begin
					count_ff[t] <= '0;
				end else if (match[t]) begin
					count_ff[t] <= '0;
				end else if (run && tick[t]) begin
					count_ff[t] <= count_ff[t] + 16'h0001;
				end
			end

			// Control high: run, mode; count-clear never stored
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_hi_ff[t] <= timer_pair_pkg::ctrl_reset;
				end else if (wr_hi) begin
					ctrl_hi_ff[t] <= pwdata[7:0] & 8'hb0;
				end else if (one_done) begin
					ctrl_hi_ff[t][timer_pair_pkg::bit_run] <= 1'b0;
				end
			end

			// Control low: flag set wins over clear; snapshot self-clears
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_lo_ff[t] <= timer_pair_pkg::ctrl_reset;
				end else begin
					if (wr_lo) begin
						ctrl_lo_ff[t] <= pwdata[7:0] & 8'hf6;
						ctrl_lo_ff[t][timer_pair_pkg::bit_irq_flag] <=
							ctrl_lo_ff[t][timer_pair_pkg::bit_irq_flag] & pwdata[timer_pair_pkg::bit_irq_flag];
					end
					if (!wr_lo && (t == 0 ? timer_a_irq_ack : timer_b_irq_ack)) begin
						ctrl_lo_ff[t][timer_pair_pkg::bit_irq_flag] <= 1'b0;
					end
					if (match[t]) begin
						ctrl_lo_ff[t][timer_pair_pkg::bit_irq_flag] <= 1'b1;
					end
				end
			end

			// Period and duty registers; capture and snapshot load duty
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					period_ff[t] <= timer_pair_pkg::data_reset;
					duty_ff[t] <= timer_pair_pkg::data_reset;
				end else begin
					if (wr_en && word_idx == {2'h0, 8'(base + 8'h02)}) period_ff[t][7:0] <= pwdata[7:0];
					if (wr_en && word_idx == {2'h0, 8'(base + 8'h03)}) period_ff[t][15:8] <= pwdata[7:0];
					if (wr_en && word_idx == {2'h0, 8'(base + 8'h04)}) duty_ff[t][7:0] <= pwdata[7:0];
					if (wr_en && word_idx == {2'h0, 8'(base + 8'h05)}) duty_ff[t][15:8] <= pwdata[7:0];
					if (run && mode == timer_pair_pkg::mode_capture && cap_evt[t]) begin
						duty_ff[t] <= count_ff[t];
					end else if (wr_lo && pwdata[timer_pair_pkg::bit_snapshot]) begin
						duty_ff[t] <= count_ff[t];
					end
				end
			end

			// Waveforms: toggle in timer mode, PWM in PROGRAMMABLE_PULSE_GEN modes
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tog_ff[t] <= 1'b0;
					wave_ff[t] <= 1'b0;
				end else if (!run) begin
					// Disabled outputs park at the idle level of the polarity
					tog_ff[t] <= pol;
					wave_ff[t] <= pol;
				end else begin
					if (mode == timer_pair_pkg::mode_timer && match[t]) begin
						tog_ff[t] <= ~tog_ff[t];
					end
					if (programmable_pulse_gen) begin
						// Active level up to duty, then idle level to period end
						wave_ff[t] <= (count_ff[t] < duty_ff[t]) ? ~pol : pol;
					end
				end
			end
		end
	endgenerate

	// APB read mux, registered
	logic [7:0] nxt_rd;
	always_comb begin
		case (word_idx[7:0])
			timer_pair_pkg::idx_a_ctrl_low: nxt_rd = ctrl_lo_ff[0];
			timer_pair_pkg::idx_a_ctrl_high: nxt_rd = ctrl_hi_ff[0];
			timer_pair_pkg::idx_a_period_low: nxt_rd = period_ff[0][7:0];
			timer_pair_pkg::idx_a_period_high: nxt_rd = period_ff[0][15:8];
			timer_pair_pkg::idx_a_duty_low: nxt_rd = duty_ff[0][7:0];
			timer_pair_pkg::idx_a_duty_high: nxt_rd = duty_ff[0][15:8];
			timer_pair_pkg::idx_a_count_low: nxt_rd = count_ff[0][7:0];
			timer_pair_pkg::idx_a_count_high: nxt_rd = count_ff[0][15:8];
			timer_pair_pkg::idx_b_ctrl_low: nxt_rd = ctrl_lo_ff[1];
			timer_pair_pkg::idx_b_ctrl_high: nxt_rd = ctrl_hi_ff[1];
			timer_pair_pkg::idx_b_period_low: nxt_rd = period_ff[1][7:0];
			timer_pair_pkg::idx_b_period_high: nxt_rd = period_ff[1][15:8];
			timer_pair_pkg::idx_b_duty_low: nxt_rd = duty_ff[1][7:0];
			timer_pair_pkg::idx_b_duty_high: nxt_rd = duty_ff[1][15:8];
			timer_pair_pkg::idx_b_count_low: nxt_rd = count_ff[1][7:0];
			timer_pair_pkg::idx_b_count_high: nxt_rd = count_ff[1][15:8];
			default: nxt_rd = 8'h00;
		endcase
	end
	logic mapped;
	assign mapped = (word_idx[9:8] == 2'h0) && (word_idx[7:0] >= timer_pair_pkg::idx_a_ctrl_low)
		&& (word_idx[7:0] <= timer_pair_pkg::idx_a_count_high)
		&& !(word_idx[7:0] == 8'hc0 || word_idx[7:0] == 8'hc1);

	// First access cycle; the answer follows one cycle later
	logic bus_access;
	logic rd_take;
	assign bus_access = psel & penable & ~pready;
	// Refused reads return zero even where the low index bits alias a register
	assign rd_take = bus_access & ~pwrite & mapped;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= bus_access;
			pslverr <= bus_access & ~mapped;
			prdata <= rd_take ? {24'h000000, nxt_rd} : 32'h0000_0000;
		end
	end

	// Pin and interrupt outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_a_toggle_out <= 1'b0;
			timer_a_pwm_out <= 1'b0;
			timer_b_toggle_out <= 1'b0;
			timer_b_pwm_out <= 1'b0;
			timer_a_irq <= 1'b0;
			timer_b_irq <= 1'b0;
		end else begin
			timer_a_toggle_out <= tog_ff[0];
			timer_a_pwm_out <= wave_ff[0];
			timer_b_toggle_out <= tog_ff[1];
			timer_b_pwm_out <= wave_ff[1];
			timer_a_irq <= ctrl_lo_ff[0][timer_pair_pkg::bit_irq_flag];
			timer_b_irq <= ctrl_lo_ff[1][timer_pair_pkg::bit_irq_flag];
		end
	end
endmodule

/* core/timer_pair_pkg.sv */
// Purpose: Shared constants for the cascadable 16-bit timer pair.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Printed offsets are not word aligned, so byte address is index times four.
package timer_pair_pkg;
	// Register indices as printed; byte address = index * 4
	localparam logic [7:0] idx_a_ctrl_low = 8'hba;
	localparam logic [7:0] idx_a_ctrl_high = 8'hbb;
	localparam logic [7:0] idx_a_period_low = 8'hbc;
	localparam logic [7:0] idx_a_period_high = 8'hbd;
	localparam logic [7:0] idx_a_duty_low = 8'hbe;
	localparam logic [7:0] idx_a_duty_high = 8'hbf;
	localparam logic [7:0] idx_b_ctrl_low = 8'hc2;
	localparam logic [7:0] idx_b_ctrl_high = 8'hc3;
	localparam logic [7:0] idx_b_period_low = 8'hc4;
	localparam logic [7:0] idx_b_period_high = 8'hc5;
	localparam logic [7:0] idx_b_duty_low = 8'hc6;
	localparam logic [7:0] idx_b_duty_high = 8'hc7;
	localparam logic [7:0] idx_b_count_low = 8'hc8;
	localparam logic [7:0] idx_b_count_high = 8'hc9;
	localparam logic [7:0] idx_a_count_low = 8'hca;
	localparam logic [7:0] idx_a_count_high = 8'hcb;
	// Control high fields
	localparam int bit_run = 7;
	localparam int bit_mode_hi = 5;
	localparam int bit_mode_lo = 4;
	localparam int bit_count_clear = 0;
	// Control low fields
	localparam int bit_clk_hi = 7;
	localparam int bit_clk_lo = 5;
	localparam int bit_irq_flag = 4;
	localparam int bit_polarity = 2;
	localparam int bit_ext_edge = 1;
	localparam int bit_snapshot = 0;
	// Reset values
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [15:0] data_reset = 16'hffff;
	// Modes
	localparam logic [1:0] mode_timer = 2'h0;
	localparam logic [1:0] mode_capture = 2'h1;
	localparam logic [1:0] mode_ppg_one = 2'h2;
	localparam logic [1:0] mode_ppg_rep = 2'h3;
	localparam logic [2:0] clk_sel_alt = 3'h7;
	localparam int presc_width = 11;
endpackage

/* testbench/timer_pair_properties.sv */
// Purpose: Register bus timing checks for timer_pair
// Assumes: One wait state, answer pulses for one cycle
// Notes: Sees only top-level ports
`timescale 1ns/1ps
module timer_pair_checker (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	wait_state_a: assert property (setup_s ##1 access_s |-> !pready) else $error("answer without wait state");
	answer_due_a: assert property (setup_s ##1 access_s |=> pready) else $error("answer late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	ready_cause_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	idle_quiet_a: assert property (!psel |-> !pready && !pslverr) else $error("answer while idle");
endmodule

bind timer_pair timer_pair_checker chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);

/* testbench/timer_pins_model.sv */
// Purpose: Pin-side partner of the timers
// Assumes: Inputs are synchronised inside the design
// Notes: Counts output edges for the bench
`timescale 1ns/1ps
module timer_pins_model (
	// Clock
	input wire logic pclk,
	// Pins
	output logic ext_clk,
	output logic cap_a,
	output logic cap_b,
	input wire logic tog_a,
	input wire logic tog_b,
	input wire logic pwm_b
);
	int n_tog_a = 0;
	int n_tog_b = 0;
	int n_pwm_b = 0;
	initial begin
		ext_clk = 1'b0;
		cap_a = 1'b0;
		cap_b = 1'b0;
	end
	always @(tog_a) n_tog_a++;
	always @(tog_b) n_tog_b++;
	always @(pwm_b) n_pwm_b++;
	// Leaves the line high so rises outnumber falls
	task ext_edges(input int n, input int half);
		repeat (n) begin
			ext_clk <= 1'b0;
			repeat (half) @(posedge pclk);
			ext_clk <= 1'b1;
			repeat (half) @(posedge pclk);
		end
	endtask
	// Long enough to pass the synchroniser
	task cap_pulse();
		@(posedge pclk);
		cap_b <= 1'b1;
		repeat (4) @(posedge pclk);
		cap_b <= 1'b0;
	endtask
endmodule

/* testbench/cascadable_16bit_timer_pair_tb_top.sv */
// Purpose: Self-checking bench for timer_pair
// Assumes: One-cycle wait state on APB
// Notes: Table covers reset values and readback
`timescale 1ns/1ps
module cascadable_16bit_timer_pair_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ack_a = 1'b0;
	logic ack_b = 1'b0;
	logic irq_a;
	logic pwm_a;
	logic ext_clk;
	logic cap_a;
	logic cap_b;
	logic tog_a;
	logic tog_b;
	logic pwm_b;
	logic irq_b;
	logic [31:0] rdat;
	logic rerr;
	int n_errors = 0;
	int n_checks = 0;
	int base;
	// Rows: write flag, index, write data, expected read
	logic [24:0] rows [26] = '{25'h0ba0000, 25'h0bb0000, 25'h0bc00ff, 25'h0bd00ff, 25'h0be00ff,
		25'h0bf00ff, 25'h0c20000, 25'h0c30000, 25'h0c400ff, 25'h0c500ff, 25'h0c600ff, 25'h0c700ff,
		25'h0c80000, 25'h0c90000, 25'h0ca0000, 25'h0cb0000, 25'h1be3c00, 25'h0be003c, 25'h1c6c300,
		25'h0c600c3, 25'h1bb8100, 25'h0bb0080, 25'h1bb0000, 25'h1ba0500, 25'h0ba0004, 25'h1ba0000};
	always #2.5 pclk = ~pclk;
	timer_pair uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_a_irq_ack(ack_a),
		.timer_b_irq_ack(ack_b), .timer_a_irq(irq_a), .timer_b_irq(irq_b), .timer_a_ext_clk_in(ext_clk),
		.timer_a_capture_in(cap_a), .timer_b_capture_in(cap_b), .timer_a_toggle_out(tog_a),
		.timer_a_pwm_out(pwm_a), .timer_b_toggle_out(tog_b), .timer_b_pwm_out(pwm_b)
	);
	timer_pins_model pm (
		.pclk(pclk), .ext_clk(ext_clk), .cap_a(cap_a), .cap_b(cap_b), .tog_a(tog_a), .tog_b(tog_b),
		.pwm_b(pwm_b)
	);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No cycle count assumed; the watchdog ends a hung wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask
	task tally_and_finish();
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			if (rows[i][24])
				apb(1'b1, rows[i][23:16], rows[i][15:8]);
			else
				rd(rows[i][23:16], rows[i][7:0]);
		end
		apb(1'b0, 8'h10, 8'h00);
		chk(32'(rerr), 32'h1);
		apb(1'b1, 8'hba, 8'h04);
		// Polarity reaches the pins through two register stages
		repeat (3) @(posedge pclk);
		chk(32'(tog_a), 32'h1);
		chk(32'(pwm_a), 32'h1);
		apb(1'b1, 8'hbc, 8'h03);
		apb(1'b1, 8'hbd, 8'h00);
		apb(1'b1, 8'hba, 8'hc0);
		base = pm.n_tog_a;
		apb(1'b1, 8'hbb, 8'h80);
		repeat (40) @(posedge pclk);
		apb(1'b1, 8'hbb, 8'h00);
		chk(32'(pm.n_tog_a - base > 4), 32'h1);
		chk(32'(irq_a), 32'h1);
		rd(8'hba, 8'hd0);
		ack_a <= 1'b1;
		@(posedge pclk);
		ack_a <= 1'b0;
		rd(8'hba, 8'hc0);
		chk(32'(irq_a), 32'h0);
		apb(1'b1, 8'hc4, 8'h02);
		apb(1'b1, 8'hc5, 8'h00);
		apb(1'b1, 8'hc2, 8'he0);
		base = pm.n_tog_b;
		apb(1'b1, 8'hc3, 8'h80);
		apb(1'b1, 8'hbb, 8'h80);
		repeat (60) @(posedge pclk);
		apb(1'b1, 8'hbb, 8'h00);
		chk(32'(pm.n_tog_b - base > 1), 32'h1);
		chk(32'(irq_b), 32'h1);
		rd(8'hc2, 8'hf0);
		apb(1'b0, 8'hc8, 8'h00);
		chk(32'(rdat < 32'h3), 32'h1);
		apb(1'b1, 8'hc3, 8'h81);
		rd(8'hc8, 8'h00);
		apb(1'b1, 8'hc3, 8'h00);
		apb(1'b1, 8'hc2, 8'hc0);
		rd(8'hc2, 8'hc0);
		apb(1'b1, 8'hc4, 8'h04);
		apb(1'b1, 8'hc6, 8'h02);
		apb(1'b1, 8'hc7, 8'h00);
		base = pm.n_pwm_b;
		apb(1'b1, 8'hc3, 8'ha0);
		repeat (30) @(posedge pclk);
		rd(8'hc3, 8'h20);
		chk(32'(pm.n_pwm_b - base), 32'h2);
		rd(8'hc2, 8'hd0);
		ack_b <= 1'b1;
		@(posedge pclk);
		ack_b <= 1'b0;
		rd(8'hc2, 8'hc0);
		apb(1'b1, 8'hc4, 8'hff);
		apb(1'b1, 8'hc5, 8'hff);
		apb(1'b1, 8'hc7, 8'hff);
		apb(1'b1, 8'hc3, 8'h90);
		pm.cap_pulse();
		repeat (8) @(posedge pclk);
		rd(8'hc7, 8'h00);
		apb(1'b1, 8'hc3, 8'h00);
		apb(1'b1, 8'hbc, 8'hff);
		apb(1'b1, 8'hbd, 8'hff);
		apb(1'b1, 8'hba, 8'he2);
		apb(1'b1, 8'hbb, 8'h80);
		pm.ext_edges(5, 3);
		repeat (8) @(posedge pclk);
		rd(8'hca, 8'h05);
		tally_and_finish();
	end
endmodule
